// file: design/pin_mux_top.sv
// port 1 and port 2 (bits 0, 2) pin function multiplexer
// Functional notes
// - P1.0: sel 0 gpio; sel 1 in feeds timer clock, out drives converter clock
// - P1.1-3: sel 1 in feeds capture inputs, out drives timer channels
// - after reset every pin is gpio input with nothing driven
// - four-wire debug turns P1.4-6 into tck, tms, tdi; dir/sel ignored
// - P1.4-6 sel 1 out: submain clock, timer channel 0, channel 1
// - P1.7 carries debug data in debug mode, else channel 2 or gpio
// - debug pins take direction and enable from debug logic only
// - P2.0 sel 1 out drives auxiliary clock; analog enable overrides
// - P2.2 sel 1 in feeds capture 0b, out channel 0; analog overrides
// - analog enable kills digital driver and input buffer of that pin
// - blown fuse refuses all debug access and holds bypass
// - pins return to normal 15 to 100 us after two-wire session ends
`timescale 1ns/1ns
`include "pin_mux_defines.svh"
module pin_mux_top (
  input  wire logic                  i_clk,              // 100 MHz clock
  input  wire logic                  i_arst_n,           // async reset
  input  wire logic                  i_ce,               // clock enable
  input  wire logic [7:0]            i_port1_direction,  // 1 = output
  input  wire logic [7:0]            i_port1_function_select, // 1 = alt
  input  wire logic [7:0]            i_port2_direction,  // bits 0, 2 used
  input  wire logic [7:0]            i_port2_function_select, // bits 0, 2
  input  wire logic [7:0]            i_analog_input_enable, // bits 0, 2
  input  wire logic                  i_four_wire_debug,  // debug mode flag
  input  wire logic                  i_fuse_blown,       // security fuse
  input  wire logic                  i_test_pin,         // test/clock pin
  input  wire logic [7:0]            i_port1_out,        // gpio out values
  input  wire logic [1:0]            i_port2_out,        // P2.2, P2.0
  input  wire logic                  i_converter_clock,  // converter clk
  input  wire logic                  i_submain_clock,    // sub-main clock
  input  wire logic                  i_aux_clock,        // auxiliary clock
  input  wire logic [2:0]            i_timer_out,        // channels 2..0
  input  wire logic                  i_dbg_data_out,     // debug data out
  input  wire logic                  i_dbg_data_oe,      // debug drives P1.7
  input  wire logic [7:0]            i_p1_pin,           // P1 pin levels
  input  wire logic [1:0]            i_p2_pin,           // P2.2, P2.0 levels
  output pin_mux_pkg::p1_drive_t     o_p1_drive,         // P1 out and oe
  output pin_mux_pkg::p2_drive_t     o_p2_drive,         // P2 out and oe
  output logic [7:0]                 o_port1_in,         // P1 input data
  output logic [1:0]                 o_port2_in,         // P2 input data
  output logic                       o_timer_clock_input, // timer clock in
  output logic [2:0]                 o_capture_in,       // from P1.3..1
  output logic                       o_capture_input_0b, // from P2.2
  output pin_mux_pkg::dbg_pins_t     o_dbg_pins,         // tck, tms, tdi
  output logic                       o_dbg_data_in,      // P1.7 as input
  output logic [1:0]                 o_analog_connect,   // P2.2, P2.0
  output logic                       o_debug_active,     // 4-wire owns pins
  output logic                       o_two_wire_active,  // 2-wire session
  output logic                       o_debug_bypass      // fuse bypass
);
  import pin_mux_pkg::*;

  logic [1:0] rst_sync_r;
  wire        rst_n = rst_sync_r[1];

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n)
      rst_sync_r <= 2'b00;
    else if (i_ce)
      rst_sync_r <= {rst_sync_r[0], 1'b1};
  end

  // pin levels are asynchronous: two stages before any use
  logic [10:0] pin_meta_r, pin_sync_r;
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta_r <= '0;
      pin_sync_r <= '0;
    end else if (i_ce) begin
      pin_meta_r <= {i_test_pin, i_p2_pin, i_p1_pin};
      pin_sync_r <= pin_meta_r;
    end
  end
  wire [7:0] p1_in   = pin_sync_r[7:0];
  wire [1:0] p2_in   = pin_sync_r[9:8];
  wire       test_in = pin_sync_r[10];

  // gather the bits that matter for port 2 (P2.2 high, P2.0 low)
  function automatic logic [1:0] p2_pick(input logic [7:0] v);
    p2_pick = {v[`P2_HI_BIT], v[`P2_LO_BIT]};
  endfunction

  wire [7:0] dir1 = i_port1_direction;
  wire [7:0] sel1 = i_port1_function_select;
  wire [1:0] dir2 = p2_pick(i_port2_direction);
  wire [1:0] sel2 = p2_pick(i_port2_function_select);
  wire [1:0] ae2  = p2_pick(i_analog_input_enable);

  wire       dbg_on = i_four_wire_debug && !i_fuse_blown;
  wire       tw_active;

  // alternate output per pin
  wire [7:0] p1_alt = {i_timer_out, i_submain_clock,
                       i_timer_out, i_converter_clock};
  wire [1:0] p2_alt = {i_timer_out[0], i_aux_clock};

  wire [7:0] p1_mask = dbg_on ? `DBG_MASK : 8'h00;
  wire [7:0] p1_dbg_out = {i_dbg_data_out, 7'h00};
  wire [7:0] p1_dbg_oe  = {i_dbg_data_oe, 7'h00};

  p1_drive_t p1_nxt;
  p2_drive_t p2_nxt;
  wire [7:0] p1_norm_out;

  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_p1
      assign p1_norm_out[g] = sel1[g] ? p1_alt[g] : i_port1_out[g];
      assign p1_nxt.out[g]  = p1_mask[g] ? p1_dbg_out[g]
                                         : p1_norm_out[g];
      assign p1_nxt.oe[g]   = p1_mask[g] ? p1_dbg_oe[g]
                                         : dir1[g];
    end
    for (g = 0; g < 2; g++) begin : g_p2
      assign p2_nxt.out[g] = sel2[g] ? p2_alt[g] : i_port2_out[g];
      assign p2_nxt.oe[g]  = dir2[g] && !ae2[g];
    end
  endgenerate

  wire [1:0] p2_in_nxt  = p2_in & ~ae2;
  wire       test_clock_input_nxt   = sel1[0] && !dir1[0] && p1_in[0];
  wire [2:0] cap_en     = sel1[3:1] & ~dir1[3:1];
  wire [2:0] cap_nxt    = cap_en & p1_in[3:1];
  wire       cap0b_nxt  = sel2[1] && !dir2[1] && !ae2[1]
                          && p2_in[1];
  dbg_pins_t dbg_nxt;
  assign dbg_nxt.tck = dbg_on && p1_in[`DBG_LO_BIT];
  assign dbg_nxt.tms = dbg_on && p1_in[`DBG_LO_BIT + 1];
  assign dbg_nxt.tdi = dbg_on && p1_in[`DBG_LO_BIT + 2];
  wire       dbg_di_nxt = dbg_on && !i_dbg_data_oe && p1_in[7];

  two_wire_watch u_tw (
    .i_clk        (i_clk),
    .i_rst_n      (rst_n),
    .i_ce         (i_ce),
    .i_test_level (test_in),
    .i_fuse_blown (i_fuse_blown),
    .o_active     (tw_active)
  );

  // every output is registered; reset leaves all pins undriven inputs
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_p1_drive          <= '{out: `RST_OUT, oe: `RST_OUT};
      o_p2_drive          <= '0;
      o_port1_in          <= '0;
      o_port2_in          <= '0;
      o_timer_clock_input <= 1'b0;
      o_capture_in        <= '0;
      o_capture_input_0b  <= 1'b0;
      o_dbg_pins          <= '0;
      o_dbg_data_in       <= 1'b0;
      o_analog_connect    <= '0;
      o_debug_active      <= 1'b0;
      o_two_wire_active   <= 1'b0;
      o_debug_bypass      <= 1'b0;
    end else if (i_ce) begin
      o_p1_drive          <= p1_nxt;
      o_p2_drive          <= p2_nxt;
      o_port1_in          <= p1_in;
      o_port2_in          <= p2_in_nxt;
      o_timer_clock_input <= test_clock_input_nxt;
      o_capture_in        <= cap_nxt;
      o_capture_input_0b  <= cap0b_nxt;
      o_dbg_pins          <= dbg_nxt;
      o_dbg_data_in       <= dbg_di_nxt;
      o_analog_connect    <= ae2;
      o_debug_active      <= dbg_on;
      o_two_wire_active   <= tw_active;
      o_debug_bypass      <= i_fuse_blown;
    end
  end

  a_analog_kills_drv: assert property (@(posedge i_clk)
    disable iff (!rst_n)
    o_analog_connect[0] |-> !o_p2_drive.oe[0] && !o_port2_in[0])
    else $error("analog pin still has digital path");

  a_analog_p22: assert property (@(posedge i_clk)
    disable iff (!rst_n)
    o_analog_connect[1] |-> !o_p2_drive.oe[1] && !o_capture_input_0b)
    else $error("P2.2 digital path live in analog mode");

  a_debug_owns_oe: assert property (@(posedge i_clk)
    disable iff (!rst_n)
    o_debug_active |-> o_p1_drive.oe[6:4] == 3'b000)
    else $error("debug pin driven from port direction");

  a_fuse_no_debug: assert property (@(posedge i_clk)
    disable iff (!rst_n)
    o_debug_bypass |-> !o_debug_active && o_dbg_pins == '0)
    else $error("debug access with fuse blown");

  a_p1_0_conv_clk: assert property (@(posedge i_clk)
    disable iff (!rst_n)
    i_ce && !dbg_on && sel1[0] && dir1[0] |=>
      o_p1_drive.oe[0] && o_p1_drive.out[0] == $past(i_converter_clock))
    else $error("P1.0 not driving converter clock");

  a_p1_ch_out: assert property (@(posedge i_clk)
    disable iff (!rst_n)
    i_ce && sel1[2] && dir1[2] |=>
      o_p1_drive.out[2] == $past(i_timer_out[1]))
    else $error("P1.2 not driving timer channel 1");

  a_p1_5_tmr: assert property (@(posedge i_clk)
    disable iff (!rst_n)
    i_ce && !dbg_on && sel1[5] && dir1[5] |=>
      o_p1_drive.oe[5] && o_p1_drive.out[5] == $past(i_timer_out[0]))
    else $error("P1.5 not driving timer channel 0");

  a_p1_7_dbg: assert property (@(posedge i_clk)
    disable iff (!rst_n)
    i_ce && dbg_on |=> o_p1_drive.oe[7] == $past(i_dbg_data_oe)
      && o_p1_drive.out[7] == $past(i_dbg_data_out))
    else $error("P1.7 not under debug control");

  a_p2_0_aux: assert property (@(posedge i_clk)
    disable iff (!rst_n)
    i_ce && sel2[0] && dir2[0] && !ae2[0] |=>
      o_p2_drive.oe[0] && o_p2_drive.out[0] == $past(i_aux_clock))
    else $error("P2.0 not driving auxiliary clock");

  a_reset_gpio: assert property (@(posedge i_clk)
    $rose(rst_n) |-> o_p1_drive.oe == 8'h00 && o_p2_drive.oe == 2'b00)
    else $error("pin driven at reset release");
endmodule // pin_mux_top

// file: design/two_wire_watch.sv
// two-wire debug entry, low-phase timeout and return-to-normal timer
`timescale 1ns/1ns
`include "pin_mux_defines.svh"
module two_wire_watch (
  input  wire logic i_clk,         // system clock
  input  wire logic i_rst_n,       // synchronised reset
  input  wire logic i_ce,          // clock enable
  input  wire logic i_test_level,  // synchronised test/clock pin
  input  wire logic i_fuse_blown,  // security fuse state
  output logic      o_active       // shared pins owned by two-wire logic
);
  import pin_mux_pkg::*;

  tw_state_t             state_r, state_nxt;
  logic [`TW_CNT_W-1:0] cnt_r, cnt_nxt;
  logic                  active_nxt;

  wire low_expired = (cnt_r == `TW_CNT_W'(`TW_LOW_MAX_CYC - 1));
  wire ret_done    = (cnt_r == `TW_CNT_W'(`TW_RET_CYC - 1));

  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    unique case (state_r)
      TW_IDLE: begin
        cnt_nxt = '0;
        if (i_test_level && !i_fuse_blown)
          state_nxt = TW_ACTIVE;
      end
      TW_ACTIVE: begin
        // low phase past the limit ends the session
        if (i_test_level)
          cnt_nxt = '0;
        else if (low_expired) begin
          state_nxt = TW_RETURN;
          cnt_nxt   = '0;
        end else
          cnt_nxt = cnt_r + 1'b1;
        if (i_fuse_blown)
          state_nxt = TW_IDLE;
      end
      TW_RETURN: begin
        cnt_nxt = cnt_r + 1'b1;
        if (ret_done)
          state_nxt = TW_IDLE;
      end
      default: state_nxt = TW_IDLE;
    endcase
  end

  assign active_nxt = (state_nxt != TW_IDLE);

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_r  <= TW_IDLE;
      cnt_r    <= '0;
      o_active <= 1'b0;
    end else if (i_ce) begin
      state_r  <= state_nxt;
      cnt_r    <= cnt_nxt;
      o_active <= active_nxt;
    end
  end

  // cycles spent in the return window, kept only for the bound check;
  // wider than cnt_r so a runaway return cannot wrap and hide
  logic [`TW_MON_W-1:0] ret_mon_r;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n)
      ret_mon_r <= '0;
    else if (i_ce) begin
      if (state_r == TW_RETURN)
        ret_mon_r <= ret_mon_r + 1'b1;
      else
        ret_mon_r <= '0;
    end
  end

  // return after session end is bounded by the longest allowed time
  a_return_bound: assert property (@(posedge i_clk)
    disable iff (!i_rst_n)
    (state_r == TW_RETURN) |-> (ret_mon_r < `TW_MON_W'(`TW_RET_MAX_CYC)))
    else $error("two-wire return took too long");

  a_fuse_blocks: assert property (@(posedge i_clk)
    disable iff (!i_rst_n)
    i_fuse_blown && i_ce |=> (state_r != TW_ACTIVE))
    else $error("two-wire session with fuse blown");
endmodule // two_wire_watch

// file: include/pin_mux_defines.svh
// constants for the port 1 / port 2 pin function multiplexer
`ifndef PIN_MUX_DEFINES_SVH
`define PIN_MUX_DEFINES_SVH
`define CLK_MHZ            100
`define TW_LOW_MAX_US      15
`define TW_RET_MIN_US      15
`define TW_RET_MAX_US      100
`define TW_EN_MAX_US       1
`define TW_LOW_MAX_CYC     (`TW_LOW_MAX_US * `CLK_MHZ)
`define TW_RET_CYC         (`TW_RET_MIN_US * `CLK_MHZ)
`define TW_RET_MAX_CYC     (`TW_RET_MAX_US * `CLK_MHZ)
`define TW_EN_MAX_CYC      (`TW_EN_MAX_US * `CLK_MHZ)
`define TW_CNT_W           12
`define TW_MON_W           14
`define DBG_LO_BIT         4
`define DBG_MASK           8'hF0
`define P2_LO_BIT          0
`define P2_HI_BIT          2
`define RST_OUT            8'h00
`endif

// file: include/pin_mux_pkg.sv
// types shared by the pin function multiplexer
package pin_mux_pkg;
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } dbg_pins_t;
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } p1_drive_t;
  typedef struct packed {
    logic [1:0] out;
    logic [1:0] oe;
  } p2_drive_t;
  typedef enum logic [1:0] {TW_IDLE, TW_ACTIVE, TW_RETURN} tw_state_t;
endpackage

// file: sim/pin_far_side.sv
// far side model: board pin levels and the two-wire debug tool
`timescale 1ns/1ns
module pin_far_side (
  input  wire logic                   i_clk,     // system clock
  input  wire logic [7:0]             i_board,   // board levels
  input  wire pin_mux_pkg::p1_drive_t i_p1,      // port 1 drive
  input  wire pin_mux_pkg::p2_drive_t i_p2,      // port 2 drive
  output logic [7:0]                  o_p1_pin,  // port 1 levels
  output logic [1:0]                  o_p2_pin,  // port 2 levels
  output logic                        o_test_pin // test clock pin
);
  import pin_mux_pkg::*;
  logic test_r = 1'b0;
  // an undriven pin follows the board, a driven one the device
  assign o_p1_pin = (i_p1.out & i_p1.oe) | (i_board & ~i_p1.oe);
  assign o_p2_pin = (i_p2.out & i_p2.oe) | (i_board[1:0] & ~i_p2.oe);
  // pulled down while no tool drives it
  assign o_test_pin = test_r;
  task automatic tw_session(input int low_len, input int n);
    test_r = 1'b1;
    repeat (150) @(negedge i_clk);
    repeat (n) begin
      test_r = 1'b0;
      repeat (low_len) @(negedge i_clk);
      test_r = 1'b1;
      repeat (20) @(negedge i_clk);
    end
    test_r = 1'b0;
  endtask
endmodule // pin_far_side

// file: sim/port1_port2_pin_function_mux_test.sv
// self-checking bench for the port 1 / port 2 pin function multiplexer
`timescale 1ns/1ns
module port1_port2_pin_function_mux_test;
  import pin_mux_pkg::*;
  logic       clk, arst_n, dbg, fuse, conv, sub, aux, dbg_out, dbg_oe;
  logic [7:0] dir1, sel1, dir2, sel2, ae, p1out, board, p1_pin, p1_in;
  logic [2:0] timer, cap;
  logic [1:0] p2out, p2_pin, p2_in, acon;
  logic       test_pin, test_clock_input_in, cap0b, dbg_in, dbg_act, tw_act, bypass;
  p1_drive_t  p1d;
  p2_drive_t  p2d;
  dbg_pins_t  dpins;
  int         mismatches, checks, n;
  // dir1 sel1 dir2 sel2 ae {debug, fuse, debug data enable}
  localparam logic [47:0] CFG [8] = '{
    48'hFF_00_05_00_00_00, 48'h00_00_00_00_00_00, 48'hFF_FF_05_05_00_00,
    48'hF0_FF_01_05_00_00, 48'hFF_FF_05_05_05_05, 48'h0F_0F_05_05_04_04,
    48'hFF_FF_05_05_00_06, 48'h00_0F_05_04_01_00};

  pin_mux_top dut (
    .i_clk(clk), .i_arst_n(arst_n), .i_ce(1'b1),
    .i_port1_direction(dir1), .i_port1_function_select(sel1),
    .i_port2_direction(dir2), .i_port2_function_select(sel2),
    .i_analog_input_enable(ae), .i_four_wire_debug(dbg),
    .i_fuse_blown(fuse), .i_test_pin(test_pin), .i_port1_out(p1out),
    .i_port2_out(p2out), .i_converter_clock(conv),
    .i_submain_clock(sub), .i_aux_clock(aux), .i_timer_out(timer),
    .i_dbg_data_out(dbg_out), .i_dbg_data_oe(dbg_oe),
    .i_p1_pin(p1_pin), .i_p2_pin(p2_pin), .o_p1_drive(p1d),
    .o_p2_drive(p2d), .o_port1_in(p1_in), .o_port2_in(p2_in),
    .o_timer_clock_input(test_clock_input_in), .o_capture_in(cap),
    .o_capture_input_0b(cap0b), .o_dbg_pins(dpins),
    .o_dbg_data_in(dbg_in), .o_analog_connect(acon),
    .o_debug_active(dbg_act), .o_two_wire_active(tw_act),
    .o_debug_bypass(bypass));
  pin_far_side far (
    .i_clk(clk), .i_board(board), .i_p1(p1d), .i_p2(p2d),
    .o_p1_pin(p1_pin), .o_p2_pin(p2_pin), .o_test_pin(test_pin));

  task automatic check(input string what, input logic [15:0] exp, got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic check_span(input string what, input int lo, hi, seen);
    checks++;
    if (seen < lo || seen > hi) begin
      mismatches++;
      $display("wrong value %s expected %0d..%0d seen %0d", what, lo, hi,
               seen);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // sources flip with inv so a stuck output cannot match both passes
  task automatic set_cfg(input logic [47:0] c, input logic inv);
    {dir1, sel1, dir2, sel2, ae} = c[47:8];
    {dbg, fuse, dbg_oe} = c[2:0];
    {conv, sub, aux, timer, dbg_out, p2out} = 9'h0AD ^ {9{inv}};
    p1out = 8'h5A ^ {8{inv}};
    board = 8'hC3 ^ {8{inv}};
  endtask
  task automatic pulse_reset();
    arst_n = 1'b0;
    repeat (3) @(negedge clk);
    check("reset drive", 16'h0000, 16'({p1d.oe, p2d.oe, acon}));
    arst_n = 1'b1;
    repeat (6) @(negedge clk);
  endtask
  task automatic check_mux();
    logic [7:0] alt, out1, oe1, pin1;
    logic [1:0] out2, oe2, pin2, a2, s2, d2;
    logic       on;
    on = dbg & ~fuse;
    alt = {timer, sub, timer, conv};
    out1 = (sel1 & alt) | (~sel1 & p1out);
    oe1 = dir1;
    if (on) begin
      oe1 = {dbg_oe, 3'b000, dir1[3:0]};
      out1[7] = dbg_out;
    end
    a2 = {ae[2], ae[0]};
    s2 = {sel2[2], sel2[0]};
    d2 = {dir2[2], dir2[0]};
    out2 = (s2 & {timer[0], aux}) | (~s2 & p2out);
    oe2 = d2 & ~a2;
    pin1 = (out1 & oe1) | (board & ~oe1);
    pin2 = (out2 & oe2) | (board[1:0] & ~oe2);
    check("p1 drive", {oe1, out1 & oe1}, {p1d.oe, p1d.out & p1d.oe});
    check("p2 drive", 16'({oe2, out2 & oe2}),
          16'({p2d.oe, p2d.out & p2d.oe}));
    check("p1 in", 16'(pin1), 16'(p1_in));
    check("p2 in", 16'(pin2 & ~a2), 16'(p2_in));
    check("capture", 16'({sel1[3:0] & ~dir1[3:0] & pin1[3:0],
          s2[1] & ~d2[1] & ~a2[1] & pin2[1]}),
          16'({cap, test_clock_input_in, cap0b}));
    check("debug", 16'({on ? {pin1[4], pin1[5], pin1[6]} : 3'b000,
          on & ~dbg_oe & pin1[7]}), 16'({dpins, dbg_in}));
    check("status", 16'({a2, on, fuse}),
          16'({acon, dbg_act, bypass}));
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (100000) @(posedge clk);
    mismatches++;
    wrap_up();
  end
  initial begin
    mismatches = 0;
    checks = 0;
    set_cfg(CFG[2], 1'b0);
    pulse_reset();
    $display("test reset done");
    foreach (CFG[i]) for (int v = 0; v < 2; v++) begin
      @(negedge clk);
      set_cfg(CFG[i], v[0]);
      repeat (6) @(negedge clk);
      check_mux();
    end
    $display("test mux table done");
    set_cfg(CFG[1], 1'b0);
    fork
      far.tw_session(1400, 3);
      begin
        repeat (1650) @(negedge clk);
        check("two wire", 16'h0001, 16'(tw_act));
      end
    join
    n = 0;
    while (tw_act === 1'b1 && n < 20000) begin
      @(negedge clk);
      n++;
    end
    if (n == 20000) begin
      mismatches++;
      wrap_up();
    end
    check_span("return time", 2990, 11510, n);
    $display("test two wire done");
    fuse = 1'b1;
    fork
      far.tw_session(20, 4);
      begin
        repeat (300) @(negedge clk);
        check("fused two wire", 16'h0000, 16'(tw_act));
      end
    join
    $display("test fused two wire done");
    @(negedge clk);
    set_cfg(CFG[5], 1'b0);
    repeat (6) @(negedge clk);
    pulse_reset();
    check_mux();
    $display("test mid reset done");
    wrap_up();
  end
endmodule // port1_port2_pin_function_mux_test
